// *** fpec_host.sv ***
// Purpose: Host sequencer that unlocks, loads and commands the flash
//          controller, with its own APB register port for software.
// Assumes: Device registers answer on the same clock over APB.
// Notes:   One operation at a time; start ignored while busy.
`timescale 1ns/100ps
`default_nettype none
module fpec_host
   import fpec_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             mPsel,
   output logic             mPenable,
   output logic             mPwrite,
   output logic      [31:0] mPaddr,
   output logic      [31:0] mPwdata,
   input  wire logic [31:0] mPrdata,
   input  wire logic        mPready,
   input  wire logic        mPslverr,
   output logic             oscEnable,
   output logic             sleepInhibit
);
   typedef struct packed {
      fpec_st_t    st;
      logic        pend;
      logic [5:0]  idx;
      fpec_op_t    op;
      logic        area;
      logic [2:0]  optEn;
      logic [31:0] taddr;
      logic [5:0]  wcnt;
      logic [4:0]  bufIdx;
      logic [4:0]  status;
      logic [31:0] erflag;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } fpec_host_t;

   fpec_host_t q;
   fpec_host_t d;
   fpec_req_t  req;
   fpec_rsp_t  rsp;
   logic       memWe;
   logic [31:0] memRdata;
   logic       swWr;
   logic       inRange;

   function automatic logic [31:0] cmdFor(fpec_op_t op, logic area);
      logic [31:0] c;
      c = CMD_BULK;
      if (op == OP_PERASE) begin
         c = area ? CMD_PE_OPT : CMD_PE_MAIN;
      end else if (op == OP_PWRITE) begin
         c = area ? CMD_PW_OPT : CMD_PW_MAIN;
      end
      return c;
   endfunction

   function automatic logic [31:0] bcrFor(logic [2:0] en);
      logic [31:0] v;
      v = BCR_BASE;
      // Only pages 0..2 have a digit, in nibbles 0..2; page 0 uses the low nibble
      for (int i = 0; i < 3; i++) begin
         v[i*4 +: 4] = en[i] ? BCR_EN_DIGIT : 4'h0;
      end
      return v;
   endfunction

   // ----------------------------------------
   // Software register port
   // ----------------------------------------
   assign swWr    = psel && penable && q.pready && pwrite;
   assign memWe   = swWr && (paddr == SW_BUFDATA) && !q.status[ST_BUSY];
   assign inRange = pwdata[2] ? (q.taddr >= OPT_LO && q.taddr <= OPT_HI)
                              : (q.taddr >= MAIN_LO && q.taddr <= MAIN_HI);

   always_comb begin
      d = q;
      d.pready  = 1'b0;
      d.pslverr = 1'b0;
      req.start = 1'b0;
      req.wr    = 1'b1;
      req.addr  = DEV_ADR_OFS;
      req.wdata = '0;
      if (psel && penable && !q.pready) begin
         d.pready = 1'b1;
         d.prdata = '0;
         if (paddr == SW_CTRL) begin
            d.prdata[6:0] = {q.optEn, 1'b0, q.area, q.op};
         end else if (paddr == SW_TADDR) begin
            d.prdata = q.taddr;
         end else if (paddr == SW_WCNT) begin
            d.prdata[5:0] = q.wcnt;
         end else if (paddr == SW_BUFIDX) begin
            d.prdata[4:0] = q.bufIdx;
         end else if (paddr == SW_STATUS) begin
            d.prdata[4:0] = q.status;
         end else if (paddr == SW_ERFLAG) begin
            d.prdata = q.erflag;
         end else if (paddr != SW_BUFDATA) begin
            d.pslverr = 1'b1;
         end
      end
      if (swWr) begin
         if (paddr == SW_STATUS) begin
            d.status[4:1] = q.status[4:1] & ~pwdata[4:1];
         end else if (!q.status[ST_BUSY]) begin
            // Settings frozen while an operation runs
            if (paddr == SW_CTRL) begin
               d.op    = fpec_op_t'(pwdata[1:0]);
               d.area  = pwdata[2];
               d.optEn = pwdata[6:4];
            end else if (paddr == SW_TADDR) begin
               d.taddr = pwdata;
            end else if (paddr == SW_WCNT) begin
               d.wcnt = (pwdata[5:0] > PAGE_WCNT) ? PAGE_WCNT : pwdata[5:0];
            end else if (paddr == SW_BUFIDX) begin
               d.bufIdx = pwdata[4:0];
            end else if (paddr == SW_BUFDATA) begin
               d.bufIdx = q.bufIdx + 5'h01;
            end
         end
      end
      // ----------------------------------------
      // Launch
      // ----------------------------------------
      if (swWr && paddr == SW_CTRL && pwdata[CTRL_START] &&
          !q.status[ST_BUSY] && pwdata[1:0] != OP_NONE) begin
         if (pwdata[1:0] != OP_BULK && !inRange) begin
            d.status[ST_RANGE] = 1'b1;
         end else begin
            d.status[ST_BUSY] = 1'b1;
            d.st  = S_RDPTR;
            d.idx = '0;
         end
      end
      // ----------------------------------------
      // Device access per step
      // ----------------------------------------
      case (q.st)
         S_RDPTR: begin
            req.wr = 1'b0;
         end
         S_PARK: begin
            req.wdata = ADR_PARK;
         end
         S_KEY1: begin
            req.addr  = DEV_KEY1_OFS;
            req.wdata = KEY_FIRST;
         end
         S_KEY2: begin
            req.addr  = DEV_KEY2_OFS;
            req.wdata = KEY_SECOND;
         end
         S_BRST: begin
            req.addr  = DEV_CR_OFS;
            req.wdata = CMD_BUF_RST;
         end
         S_FILL: begin
            req.addr  = (q.taddr & PAGE_MASK) | {25'h0, q.idx[4:0], 2'b00};
            req.wdata = (q.op == OP_PERASE) ? ERASE_WORD : memRdata;
         end
         S_BCR: begin
            req.addr  = DEV_BCR_OFS;
            req.wdata = bcrFor(q.optEn);
         end
         S_ADR: begin
            req.wdata = (q.op == OP_BULK) ? ADR_BULK : (q.taddr & PAGE_MASK);
         end
         S_CHK1: begin
            req.wr   = 1'b0;
            req.addr = DEV_KEY1_OFS;
         end
         S_CHK2: begin
            req.wr   = 1'b0;
            req.addr = DEV_KEY2_OFS;
         end
         S_CMD: begin
            req.addr  = DEV_CR_OFS;
            req.wdata = cmdFor(q.op, q.area);
         end
         S_POLL: begin
            req.wr   = 1'b0;
            req.addr = DEV_CR_OFS;
         end
         S_FLAG: begin
            req.wr   = 1'b0;
            req.addr = DEV_ERF_OFS;
         end
         default: begin
            req.wr = 1'b1;
         end
      endcase
      if (q.st != S_IDLE && !q.pend) begin
         req.start = 1'b1;
         d.pend    = 1'b1;
      end
      if (rsp.done) begin
         d.pend = 1'b0;
         case (q.st)
            S_RDPTR: d.st = (rsp.rdata == ADR_IDLE) ? S_PARK : S_IDLE;
            S_PARK:  d.st = S_KEY1;
            S_KEY1:  d.st = S_KEY2;
            S_KEY2:  d.st = S_BRST;
            S_BRST: begin
               if (q.op == OP_BULK) begin
                  d.st = (q.optEn != 3'h0) ? S_BCR : S_ADR;
               end else if (q.op == OP_PWRITE && q.wcnt == 6'h00) begin
                  d.st = S_ADR;
               end else begin
                  d.st = S_FILL;
               end
            end
            S_FILL: begin
               d.idx = q.idx + 6'h01;
               if (d.idx == ((q.op == OP_PERASE) ? PAGE_WCNT : q.wcnt)) begin
                  d.st = S_ADR;
               end
            end
            S_BCR:   d.st = S_ADR;
            S_ADR:   d.st = S_CHK1;
            S_CHK1:  d.st = (rsp.rdata == KEY_FIRST) ? S_CHK2 : S_IDLE;
            S_CHK2:  d.st = (rsp.rdata == KEY_SECOND) ? S_CMD : S_IDLE;
            S_CMD:   d.st = S_POLL;
            S_POLL:  d.st = rsp.rdata[CR_BUSY_BIT] ? S_POLL : S_FLAG;
            S_FLAG: begin
               d.st     = S_IDLE;
               d.erflag = rsp.rdata;
               d.status[ST_DONE] = 1'b1;
               if (rsp.rdata != 32'h00000000) begin
                  d.status[ST_DEVERR] = 1'b1;
               end
            end
            default: d.st = S_IDLE;
         endcase
         if (rsp.err) begin
            d.st = S_IDLE;
         end
         // Refused key, pointer not idle, or slave error: flag a sequence error
         if (d.st == S_IDLE && q.st != S_FLAG) begin
            d.status[ST_SEQERR] = 1'b1;
         end
         if (d.st == S_IDLE) begin
            d.status[ST_BUSY] = 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   fpec_page_mem u_mem (
      .clk   (clk),
      .rst   (rst),
      .we    (memWe),
      .waddr (q.bufIdx),
      .wdata (pwdata),
      .raddr (d.idx[4:0]),
      .rdata (memRdata)
   );

   fpec_apb_master u_mst (
      .clk      (clk),
      .rst      (rst),
      .req      (req),
      .rsp      (rsp),
      .mPsel    (mPsel),
      .mPenable (mPenable),
      .mPwrite  (mPwrite),
      .mPaddr   (mPaddr),
      .mPwdata  (mPwdata),
      .mPrdata  (mPrdata),
      .mPready  (mPready),
      .mPslverr (mPslverr)
   );

   assign prdata       = q.prdata;
   assign pready       = q.pready;
   assign pslverr      = q.pslverr;
   assign oscEnable    = q.status[ST_BUSY];
   assign sleepInhibit = q.status[ST_BUSY];

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   key1_value_a: assert property (@(posedge clk) disable iff (rst)
      (mPsel && !mPenable && mPwrite && mPaddr == DEV_KEY1_OFS)
         |-> mPwdata == KEY_FIRST)
      else $error("first key write carries wrong value");
   key_order_a: assert property (@(posedge clk) disable iff (rst)
      (q.st == S_KEY2 && $past(q.st) != S_KEY2)
         |-> $past(q.st) == S_KEY1 && $past(q.st, 2) == S_KEY1)
      else $error("second key not right after first");
   bufrst_cmd_a: assert property (@(posedge clk) disable iff (rst)
      (q.st == S_BRST && mPsel && !mPenable) |-> mPwdata == CMD_BUF_RST
         && mPaddr == DEV_CR_OFS)
      else $error("buffer reset command wrong");
   erase_fill_a: assert property (@(posedge clk) disable iff (rst)
      (q.st == S_FILL && q.op == OP_PERASE && mPsel)
         |-> mPwdata == ERASE_WORD)
      else $error("erase fill word not all ones");
   cmd_code_a: assert property (@(posedge clk) disable iff (rst)
      (q.st == S_CMD && mPsel && !mPenable)
         |-> mPwdata == cmdFor(q.op, q.area))
      else $error("operation command code wrong");
   bcr_form_a: assert property (@(posedge clk) disable iff (rst)
      (mPsel && mPwrite && mPaddr == DEV_BCR_OFS)
         |-> mPwdata[31:12] == BCR_BASE[31:12] && q.optEn != 3'h0)
      else $error("bulk permit pattern malformed");
   check_order_a: assert property (@(posedge clk) disable iff (rst)
      (q.st == S_CMD && $past(q.st) != S_CMD) |-> $past(q.st) == S_CHK2)
      else $error("command issued without key readback");
   osc_hold_a: assert property (@(posedge clk) disable iff (rst)
      (q.st != S_IDLE) |-> oscEnable && sleepInhibit)
      else $error("oscillator or sleep hold dropped mid operation");
   poll_busy_a: assert property (@(posedge clk) disable iff (rst)
      (q.st == S_POLL && rsp.done && rsp.rdata[CR_BUSY_BIT])
         |=> q.st == S_POLL ##[1:3] mPsel && mPaddr == DEV_CR_OFS)
      else $error("busy seen but polling stopped");
   page_align_a: assert property (@(posedge clk) disable iff (rst)
      (q.st == S_ADR && mPsel && !mPenable)
         |-> (q.op == OP_BULK) ? mPwdata == ADR_BULK : mPwdata[6:0] == 7'h00)
      else $error("target pointer value wrong");
endmodule
`default_nettype wire

// *** fpec_pkg.sv ***
// Purpose: Shared constants and types of the flash sequencing host.
// Assumes: Device registers sit on a same-clock APB; 32-bit words.
// Notes:   Device register offsets other than the error flags are
//          placed by this block.
// Operation
// - Permit pattern digit 5 erases option page
// - Park pointer, then first, second key
// - Buffer reset command after unlock
// - Erase fills buffer with all ones
// - Write loads buffer while pointer parked
// - Target address, then read both keys
// - Page erase command codes per area
// - Page write command codes per area
// - Bulk erase pointer value and command
// - Poll busy until zero
// - Oscillator on, no sleep during operations
`default_nettype none
package fpec_pkg;
   // ----------------------------------------
   // Device register map
   // ----------------------------------------
   localparam logic [31:0] DEV_ADR_OFS   = 32'h40001b00;
   localparam logic [31:0] DEV_KEY1_OFS  = 32'h40001b04;
   localparam logic [31:0] DEV_KEY2_OFS  = 32'h40001b08;
   localparam logic [31:0] DEV_CR_OFS    = 32'h40001b0c;
   localparam logic [31:0] DEV_BCR_OFS   = 32'h40001b10;
   localparam logic [31:0] DEV_ERF_OFS   = 32'h40001b14;
   localparam int          CR_BUSY_BIT   = 16;
   // ----------------------------------------
   // Sequence values
   // ----------------------------------------
   localparam logic [31:0] ADR_IDLE      = 32'h5fffff80;
   localparam logic [31:0] ADR_PARK      = 32'h5fffffff;
   localparam logic [31:0] ADR_BULK      = 32'h5f9a30d7;
   localparam logic [31:0] KEY_FIRST     = 32'h08192a3b;
   localparam logic [31:0] KEY_SECOND    = 32'h4c5d6e7f;
   localparam logic [31:0] CMD_BUF_RST   = 32'h6c930001;
   localparam logic [31:0] CMD_PE_MAIN   = 32'h6c93a402;
   localparam logic [31:0] CMD_PE_OPT    = 32'h6c933802;
   localparam logic [31:0] CMD_PW_MAIN   = 32'h6c93a404;
   localparam logic [31:0] CMD_PW_OPT    = 32'h6c933804;
   localparam logic [31:0] CMD_BULK      = 32'h6c93a408;
   localparam logic [31:0] ERASE_WORD    = 32'hffffffff;
   localparam logic [31:0] BCR_BASE      = 32'hc1be0000;
   localparam logic [3:0]  BCR_EN_DIGIT  = 4'h5;
   localparam logic [31:0] MAIN_LO       = 32'h10000000;
   localparam logic [31:0] MAIN_HI       = 32'h17ffffff;
   localparam logic [31:0] OPT_LO        = 32'h1ffff000;
   localparam logic [31:0] OPT_HI        = 32'h1fffffff;
   localparam logic [31:0] PAGE_MASK     = 32'hffffff80;
   localparam int          PAGE_WORDS    = 32;
   localparam logic [5:0]  PAGE_WCNT     = 6'h20;
   // ----------------------------------------
   // Software register map
   // ----------------------------------------
   localparam logic [11:0] SW_CTRL       = 12'h000;
   localparam logic [11:0] SW_TADDR      = 12'h004;
   localparam logic [11:0] SW_WCNT       = 12'h008;
   localparam logic [11:0] SW_BUFIDX     = 12'h00c;
   localparam logic [11:0] SW_BUFDATA    = 12'h010;
   localparam logic [11:0] SW_STATUS     = 12'h014;
   localparam logic [11:0] SW_ERFLAG     = 12'h018;
   localparam int          CTRL_START    = 3;
   localparam int          ST_BUSY       = 0;
   localparam int          ST_DONE       = 1;
   localparam int          ST_SEQERR     = 2;
   localparam int          ST_DEVERR     = 3;
   localparam int          ST_RANGE      = 4;

   typedef enum logic [1:0] {
      OP_NONE, OP_PERASE, OP_PWRITE, OP_BULK
   } fpec_op_t;

   typedef enum logic [3:0] {
      S_IDLE, S_RDPTR, S_PARK, S_KEY1, S_KEY2, S_BRST, S_FILL, S_BCR,
      S_ADR, S_CHK1, S_CHK2, S_CMD, S_POLL, S_FLAG
   } fpec_st_t;

   typedef struct packed {
      logic        start;
      logic        wr;
      logic [31:0] addr;
      logic [31:0] wdata;
   } fpec_req_t;

   typedef struct packed {
      logic        done;
      logic        err;
      logic [31:0] rdata;
   } fpec_rsp_t;
endpackage
`default_nettype wire

// *** fpec_page_mem.sv ***
// Purpose: Page data store for one 128-byte page write.
// Assumes: One write and one read port on the same clock.
// Notes:   Read data arrive one cycle after the address.
`timescale 1ns/100ps
`default_nettype none
module fpec_page_mem
   import fpec_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        we,
   input  wire logic [4:0]  waddr,
   input  wire logic [31:0] wdata,
   input  wire logic [4:0]  raddr,
   output logic      [31:0] rdata
);
   typedef struct packed {
      logic [PAGE_WORDS-1:0][31:0] mem;
      logic [31:0]                 rd;
   } fpec_mem_t;

   fpec_mem_t q;
   fpec_mem_t d;

   always_comb begin
      d = q;
      d.rd = q.mem[raddr];
      if (we) begin
         d.mem[waddr] = wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign rdata = q.rd;
endmodule
`default_nettype wire

// *** fpec_apb_master.sv ***
// Purpose: APB master carrying one device register access at a time.
// Assumes: start only while idle; fields valid in the start cycle.
// Notes:   done is a one-cycle pulse after the completing edge.
`timescale 1ns/100ps
`default_nettype none
module fpec_apb_master
   import fpec_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire fpec_req_t   req,
   output fpec_rsp_t        rsp,
   output logic             mPsel,
   output logic             mPenable,
   output logic             mPwrite,
   output logic      [31:0] mPaddr,
   output logic      [31:0] mPwdata,
   input  wire logic [31:0] mPrdata,
   input  wire logic        mPready,
   input  wire logic        mPslverr
);
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [31:0] paddr;
      logic [31:0] pwdata;
      fpec_rsp_t   rsp;
   } fpec_mst_t;

   fpec_mst_t q;
   fpec_mst_t d;

   always_comb begin
      d = q;
      d.rsp.done = 1'b0;
      if (!q.psel) begin
         if (req.start) begin
            d.psel   = 1'b1;
            d.pwrite = req.wr;
            d.paddr  = req.addr;
            d.pwdata = req.wdata;
         end
      end else if (!q.penable) begin
         d.penable = 1'b1;
      end else if (mPready) begin
         // Request held until this edge; only then released
         d.psel      = 1'b0;
         d.penable   = 1'b0;
         d.rsp.done  = 1'b1;
         d.rsp.err   = mPslverr;
         d.rsp.rdata = mPrdata;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign rsp      = q.rsp;
   assign mPsel    = q.psel;
   assign mPenable = q.penable;
   assign mPwrite  = q.pwrite;
   assign mPaddr   = q.paddr;
   assign mPwdata  = q.pwdata;

   hold_req_a: assert property (@(posedge clk) disable iff (rst)
      (mPsel && !(mPenable && mPready)) |=>
         mPsel && $stable(mPaddr) && $stable(mPwdata))
      else $error("device request changed before ready");
endmodule
`default_nettype wire

// *** fpec_dev_model.sv ***
// Purpose: Behavioural flash controller facing the sequencing host.
// Assumes: Word accesses only; slowMode adds three wait states.
// Notes:   Busy lasts OP_CYC cycles after an accepted command.
`timescale 1ns/100ps
`default_nettype none
module fpec_dev_model
   import fpec_pkg::*;
#(
   parameter int OP_CYC = 20
)(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        mPsel,
   input  wire logic        mPenable,
   input  wire logic        mPwrite,
   input  wire logic [31:0] mPaddr,
   input  wire logic [31:0] mPwdata,
   output logic      [31:0] mPrdata,
   output logic             mPready,
   output logic             mPslverr,
   input  wire logic        slowMode,
   input  wire logic        errInject,
   output logic      [31:0] adr_q,
   output logic      [31:0] cmd_q,
   output logic      [31:0] bcr_q,
   output logic      [31:0] opAdr_q,
   output logic      [31:0] fillAdr_q,
   output logic      [31:0] fillLast_q,
   output logic      [7:0]  fillCnt_q
);
   logic [31:0] key1_q, key2_q, cr_q, erf_q, rdVal;
   logic [7:0]  busyCnt_q;
   logic [1:0]  wait_q;
   logic        busy, wrEn;
   assign busy = busyCnt_q != 8'h00;
   assign wrEn = mPsel && mPenable && mPready && mPwrite && !busy;
   always_comb begin
      case (mPaddr)
         DEV_ADR_OFS:  rdVal = adr_q;
         DEV_KEY1_OFS: rdVal = key1_q;
         DEV_KEY2_OFS: rdVal = key2_q;
         DEV_CR_OFS:   rdVal = {cr_q[31:17], busy, cr_q[15:0]};
         DEV_ERF_OFS:  rdVal = erf_q;
         default:      rdVal = 32'h0;
      endcase
   end
   // ----------------------------------------
   // Answer and register update
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         {key1_q, key2_q, cr_q, erf_q, cmd_q, bcr_q, opAdr_q} <= '0;
         {fillAdr_q, fillLast_q, fillCnt_q, busyCnt_q, wait_q} <= '0;
         {mPrdata, mPready, mPslverr} <= '0;
         adr_q <= ADR_IDLE;
      end else begin
         wait_q <= (mPsel && mPenable && !mPready) ? wait_q + 2'h1 : 2'h0;
         mPready <= mPsel && mPenable && !mPready
                    && (!slowMode || wait_q == 2'h3);
         mPslverr <= errInject;
         // Released bus inverts its last read data every cycle
         mPrdata <= (mPsel && mPenable && !mPready) ? rdVal : ~mPrdata;
         if (busy) busyCnt_q <= busyCnt_q - 8'h01;
         if (busyCnt_q == 8'h01) begin
            adr_q <= ADR_IDLE;
            cr_q  <= 32'h0;
         end
         if (wrEn) begin
            case (mPaddr)
               DEV_ADR_OFS:  adr_q <= mPwdata;
               DEV_KEY1_OFS: key1_q <= (mPwdata == KEY_FIRST
                  && adr_q == ADR_PARK) ? mPwdata : 32'h0;
               DEV_KEY2_OFS: key2_q <= (mPwdata == KEY_SECOND
                  && key1_q == KEY_FIRST) ? mPwdata : 32'h0;
               // Page 0 enable digit sits in the lowest nibble
               DEV_BCR_OFS:  bcr_q <= mPwdata;
               DEV_CR_OFS: begin
                  cmd_q <= mPwdata;
                  cr_q  <= mPwdata;
                  if (mPwdata == CMD_BUF_RST) begin
                     fillCnt_q  <= 8'h00;
                     fillLast_q <= 32'h0;
                  end else if (key1_q == KEY_FIRST && key2_q == KEY_SECOND)
                  begin
                     busyCnt_q <= 8'(OP_CYC);
                     opAdr_q   <= adr_q & PAGE_MASK;
                  end else begin
                     erf_q  <= 32'h1;
                     adr_q  <= ADR_IDLE;
                     key1_q <= 32'h0;
                     key2_q <= 32'h0;
                  end
               end
               default: if (adr_q == ADR_PARK) begin
                  fillCnt_q  <= fillCnt_q + 8'h01;
                  fillAdr_q  <= mPaddr;
                  fillLast_q <= mPwdata;
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// *** fpec_host_tb.sv ***
// Purpose: Self-checking bench of the flash sequencing host.
// Assumes: Device side is the behavioural model.
// Notes:   Software side is driven as an APB master.
`timescale 1ns/100ps
`default_nettype none
module fpec_host_tb
   import fpec_pkg::*;
;
   logic        clk, rst, psel, penable, pwrite, pready, pslverr, err;
   logic        mPsel, mPenable, mPwrite, mPready, mPslverr;
   logic        oscEnable, sleepInhibit, slowMode, errInject;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, mPaddr, mPwdata, mPrdata, rd;
   logic [31:0] adr_q, cmd_q, bcr_q, opAdr_q, fillAdr_q, fillLast_q;
   logic [7:0]  fillCnt_q;
   int          nErrors, checksDone;
   fpec_host uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .mPsel(mPsel),
      .mPenable(mPenable), .mPwrite(mPwrite), .mPaddr(mPaddr),
      .mPwdata(mPwdata), .mPrdata(mPrdata), .mPready(mPready),
      .mPslverr(mPslverr), .oscEnable(oscEnable),
      .sleepInhibit(sleepInhibit));
   fpec_dev_model dev (.clk(clk), .rst(rst), .mPsel(mPsel),
      .mPenable(mPenable), .mPwrite(mPwrite), .mPaddr(mPaddr),
      .mPwdata(mPwdata), .mPrdata(mPrdata), .mPready(mPready),
      .mPslverr(mPslverr), .slowMode(slowMode), .errInject(errInject),
      .adr_q(adr_q), .cmd_q(cmd_q), .bcr_q(bcr_q), .opAdr_q(opAdr_q),
      .fillAdr_q(fillAdr_q), .fillLast_q(fillLast_q),
      .fillCnt_q(fillCnt_q));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic complete_run;
      if (nErrors == 0 && checksDone > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, exp, input string m);
      checksDone++;
      if (seen !== exp) begin
         nErrors++;
         $display("wrong value at %0t: %s %h/%h", $time, m, seen, exp);
      end
   endtask
   // ----------------------------------------
   // Software bus cycles
   // ----------------------------------------
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] e,
                      input string m);
      apb(1'b0, a, 32'h0);
      chk(rd, e, m);
   endtask
   task automatic wait_idle;
      do begin
         apb(1'b0, SW_STATUS, 32'h0);
      end while (rd[ST_BUSY] !== 1'b0);
   endtask
   task automatic run_op(input logic [31:0] ctl, ta, cmd, fl,
                         input logic [7:0] fc);
      apb(1'b1, SW_TADDR, ta);
      apb(1'b1, SW_CTRL, ctl);
      rdc(SW_STATUS, 32'h1, "busy");
      chk({31'h0, oscEnable & sleepInhibit}, 32'h1, "osc");
      apb(1'b1, SW_TADDR, 32'h0);
      wait_idle();
      chk(rd, 32'h2, "status");
      rdc(SW_TADDR, ta, "taddr");
      rdc(SW_ERFLAG, 32'h0, "erflag");
      chk(cmd_q, cmd, "cmd");
      chk(opAdr_q, (cmd == CMD_BULK ? ADR_BULK : ta) & PAGE_MASK, "pg");
      chk(adr_q, ADR_IDLE, "park");
      chk({24'h0, fillCnt_q}, {24'h0, fc}, "fill");
      chk(fillLast_q, fl, "data");
      if (fc != 8'h00)
         chk(fillAdr_q, (ta & PAGE_MASK) + {22'h0, fc - 8'h01, 2'h0},
             "ia");
      apb(1'b1, SW_STATUS, 32'h1e);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_refuse;
      rdc(SW_STATUS, 32'h0, "rst");
      rdc(12'h100, 32'h0, "unmapped");
      chk({31'h0, err}, 32'h1, "slverr");
      apb(1'b1, SW_TADDR, 32'h18000000);
      apb(1'b1, SW_CTRL, 32'h9);
      rdc(SW_STATUS, 32'h10, "range main");
      apb(1'b1, SW_STATUS, 32'h1e);
      apb(1'b1, SW_TADDR, 32'h10000000);
      apb(1'b1, SW_CTRL, 32'hd);
      rdc(SW_STATUS, 32'h10, "range opt");
      apb(1'b1, SW_STATUS, 32'h1e);
      errInject <= 1'b1;
      apb(1'b1, SW_CTRL, 32'h9);
      wait_idle();
      errInject <= 1'b0;
      chk(rd, 32'h4, "abort");
      apb(1'b1, SW_STATUS, 32'h0);
      rdc(SW_STATUS, 32'h4, "sticky");
      apb(1'b1, SW_STATUS, 32'h4);
      rdc(SW_STATUS, 32'h0, "cleared");
   endtask
   task automatic t_pages;
      apb(1'b1, SW_BUFIDX, 32'h0);
      apb(1'b1, SW_BUFDATA, 32'h0123abcd);
      apb(1'b1, SW_BUFDATA, 32'h5a5aa5a5);
      apb(1'b1, SW_WCNT, 32'h2);
      rdc(SW_BUFIDX, 32'h2, "bufidx");
      run_op(32'h9, 32'h10000085, CMD_PE_MAIN, ERASE_WORD, 8'h20);
      run_op(32'hd, 32'h1ffff000, CMD_PE_OPT, ERASE_WORD, 8'h20);
      slowMode <= 1'b1;
      run_op(32'ha, 32'h17ffffff, CMD_PW_MAIN, 32'h5a5aa5a5, 8'h02);
      slowMode <= 1'b0;
      run_op(32'he, 32'h1fffffff, CMD_PW_OPT, 32'h5a5aa5a5, 8'h02);
   endtask
   task automatic t_bulk;
      run_op(32'h5b, 32'h12345678, CMD_BULK, 32'h0, 8'h00);
      chk(bcr_q, 32'hc1be0505, "permit");
   endtask
   initial begin
      {rst, psel, penable, pwrite, slowMode, errInject} = 6'h20;
      {paddr, pwdata} = '0;
      nErrors = 0;
      checksDone = 0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_refuse();
      t_pages();
      t_bulk();
      complete_run();
   end
   initial begin
      repeat (60000) @(posedge clk);
      nErrors++;
      complete_run();
   end
endmodule
`default_nettype wire
